/* File: rtl/rx_status_pkg.sv */
// Package: register map, field layout and constants of the serial receiver
package rx_status_pkg;

	localparam int unsigned ADDR_W = 3;
	localparam int unsigned REG_W  = 8;

	localparam logic [ADDR_W-1:0] ADDR_CTRL     = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_DATA     = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_BAUD     = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 3'h5;

	localparam int unsigned ST_OVERRUN_BIT  = 0;
	localparam int unsigned ST_FRAME_BIT    = 1;
	localparam int unsigned ST_COMPLETE_BIT = 2;
	localparam int unsigned ST_IDLE_BIT     = 3;
	localparam int unsigned INT_W           = 4;

	localparam int unsigned CLK_HZ       = 20_000_000;
	localparam logic [7:0]  BAUD_RESET   = 8'h81;
	localparam logic [3:0]  FIRST_TICK   = 4'h0;
	localparam logic [3:0]  MID_TICK     = 4'h7;
	localparam logic [3:0]  LAST_TICK    = 4'hF;
	localparam logic [4:0]  BIT_TICKS    = 5'h10;
	localparam logic [1:0]  CTRL_RESET   = 2'h0;
	localparam logic [3:0]  INT_RESET    = 4'h0;

	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

	// Bit 1 continuous receive enable, bit 0 serial port enable
	typedef struct packed {
		logic continuousReceiveEnable;
		logic serialPortEnable;
	} rx_ctrl_t;

	// Bits 3..0 of interrupt status and mask
	typedef struct packed {
		logic invalidStart;
		logic frameError;
		logic overrun;
		logic received;
	} rx_events_t;

endpackage : rx_status_pkg

/* File: rtl/rx_front_end.sv */
// RX pin synchroniser and restartable sixteen-times oversampling tick
`timescale 1ns/1ps
module rx_front_end
	import rx_status_pkg::*;
#(
	parameter int unsigned DIV_W = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             rxPin,
	input  wire logic [DIV_W-1:0] divisor,
	input  wire logic             restart,
	output logic                  rxLevel,
	output logic                  tick
);

	if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div
		$error("rx_front_end: DIV_W out of range");
	end

	logic             syncFirst_q;
	logic             syncSecond_q;
	logic [DIV_W-1:0] divCnt_q;
	logic [DIV_W-1:0] divCnt_d;
	logic             tickHit;

	// Idle line is high, so the synchroniser resets to one
	always_ff @(posedge clk) begin
		if (rst) begin
			syncFirst_q  <= 1'b1;
			syncSecond_q <= 1'b1;
		end else begin
			syncFirst_q  <= rxPin;
			syncSecond_q <= syncFirst_q;
		end
	end

	// Restart realigns the tick to a start edge so the first check lands
	// exactly one sixteenth of a bit after it
	assign tickHit  = (divCnt_q == divisor);
	assign divCnt_d = (restart || tickHit) ? '0 : divCnt_q + 1'b1;

	always_ff @(posedge clk) begin
		if (rst) begin
			divCnt_q <= '0;
		end else begin
			divCnt_q <= divCnt_d;
		end
	end

	assign rxLevel = syncSecond_q;
	assign tick    = tickHit && !restart;

endmodule : rx_front_end

/* File: rtl/uart_rx_overrun_idle_status.sv */
// Serial receiver with overrun recovery and receive-idle status behaviour
`timescale 1ns/1ps
module uart_rx_overrun_idle_status
	import rx_status_pkg::*;
#(
	parameter int unsigned DATA_BITS = 8
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              rxPin,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [REG_W-1:0]  regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [REG_W-1:0]  regRdata,
	output logic                   irq
);

	if (DATA_BITS < 5 || DATA_BITS > REG_W) begin : g_bad_width
		$error("uart_rx_overrun_idle_status: DATA_BITS out of range");
	end

	localparam int unsigned BIT_W = $clog2(DATA_BITS);
	localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(DATA_BITS - 1);

	function automatic logic atTick(input logic t, input logic [3:0] cnt,
		input logic [3:0] pos);
		atTick = t && (cnt == pos);
	endfunction : atTick

	// Register file
	rx_ctrl_t             ctrl_q;
	logic [7:0]           baud_q;
	rx_events_t           intStat_q;
	rx_events_t           intStat_d;
	rx_events_t           intMask_q;
	logic [REG_W-1:0]     rdata_q;
	logic [REG_W-1:0]     rdSel;
	logic [REG_W-1:0]     statusWord;

	// Receiver
	rx_state_t            state_q;
	rx_state_t            state_d;
	logic [3:0]           tickCnt_q;
	logic [3:0]           tickCnt_d;
	logic [BIT_W-1:0]     bitCnt_q;
	logic [BIT_W-1:0]     bitCnt_d;
	logic [DATA_BITS-1:0] shift_q;
	logic [DATA_BITS-1:0] shift_d;
	logic [DATA_BITS-1:0] hold_q;
	logic                 holdFrame_q;
	logic                 receiveCompleteFlag_q;
	logic                 receiveCompleteFlag_d;
	logic                 overrunErrorFlag_q;
	logic                 overrunErrorFlag_d;
	logic                 rxPrev_q;

	// Idle status tracking
	logic                 receiveIdleStatus_q;
	logic                 receiveIdleStatus_d;
	logic                 glitchSeen_q;
	logic                 glitchSeen_d;
	logic [4:0]           edgeTicks_q;
	logic [4:0]           edgeTicks_d;
	logic                 delayed_q;
	logic                 delayed_d;
	logic [3:0]           delayCnt_q;
	logic [3:0]           delayCnt_d;
	logic                 stuck_q;
	logic                 stuck_d;

	logic                 rxLevel;
	logic                 tick;

	// Decode
	wire wrCtrl    = regWr && (regAddr == ADDR_CTRL);
	wire wrBaud    = regWr && (regAddr == ADDR_BAUD);
	wire wrIntStat = regWr && (regAddr == ADDR_INT_STAT);
	wire wrIntMask = regWr && (regAddr == ADDR_INT_MASK);
	wire rdData    = regRd && (regAddr == ADDR_DATA);

	wire rxEnable  = ctrl_q.serialPortEnable
		&& ctrl_q.continuousReceiveEnable;
	wire rxReset   = !rxEnable;
	wire rxFall    = rxPrev_q && !rxLevel;

	// A receiver stopped by overrun takes no new start edge
	wire startEdge = (state_q == RX_IDLE) && rxFall && rxEnable
		&& !overrunErrorFlag_q;
	wire secondEdge = startEdge && glitchSeen_q && !delayed_q
		&& (edgeTicks_q < BIT_TICKS);
	// Events are dropped in the cycle the receiver is switched off
	wire inStart   = (state_q == RX_START) && rxEnable;
	// Line back high at the first sixteenth, or at mid bit, is no start
	wire startBad  = inStart && rxLevel
		&& (atTick(tick, tickCnt_q, FIRST_TICK)
		|| atTick(tick, tickCnt_q, MID_TICK));
	wire startGood = inStart && atTick(tick, tickCnt_q, LAST_TICK);
	wire charDone  = (state_q == RX_STOP) && rxEnable
		&& atTick(tick, tickCnt_q, MID_TICK);
	wire stopBad   = charDone && !rxLevel;
	wire storeChar = charDone && !receiveCompleteFlag_q;
	wire overrunEv = charDone && receiveCompleteFlag_q;
	wire delayDone = delayed_q && atTick(tick, delayCnt_q, LAST_TICK);

	rx_front_end #(
		.DIV_W   (8)
	) u_front (
		.clk     (clk),
		.rst     (rst),
		.rxPin   (rxPin),
		.divisor (baud_q),
		.restart (startEdge),
		.rxLevel (rxLevel),
		.tick    (tick)
	);

	// Character framing, LSB first, stop checked at mid bit
	always_comb begin
		state_d   = state_q;
		tickCnt_d = tick ? tickCnt_q + 4'h1 : tickCnt_q;
		bitCnt_d  = bitCnt_q;
		shift_d   = shift_q;
		case (state_q)
			RX_IDLE: begin
				tickCnt_d = FIRST_TICK;
				if (startEdge) begin
					state_d = RX_START;
				end
			end
			RX_START: begin
				if (startBad) begin
					state_d = RX_IDLE;
				end else if (startGood) begin
					state_d  = RX_DATA;
					bitCnt_d = '0;
				end
			end
			RX_DATA: begin
				if (atTick(tick, tickCnt_q, MID_TICK)) begin
					shift_d = {rxLevel, shift_q[DATA_BITS-1:1]};
				end
				if (atTick(tick, tickCnt_q, LAST_TICK)) begin
					if (bitCnt_q == LAST_BIT) begin
						state_d = RX_STOP;
					end else begin
						bitCnt_d = bitCnt_q + 1'b1;
					end
				end
			end
			RX_STOP: begin
				if (charDone) begin
					state_d = RX_IDLE;
				end
			end
			default: begin
				state_d = RX_IDLE;
			end
		endcase
		if (rxReset) begin
			state_d = RX_IDLE;
		end
	end

	// Idle status: a bad start followed closely by another fall holds the
	// idle drop back one bit; a second bad start then leaves idle low
	always_comb begin
		receiveIdleStatus_d = receiveIdleStatus_q;
		glitchSeen_d        = glitchSeen_q;
		edgeTicks_d         = edgeTicks_q;
		delayed_d           = delayed_q;
		delayCnt_d          = delayCnt_q;
		stuck_d             = stuck_q;
		if (tick && edgeTicks_q < BIT_TICKS) begin
			edgeTicks_d = edgeTicks_q + 5'h01;
		end
		if (tick && edgeTicks_q == BIT_TICKS - 5'h01) begin
			glitchSeen_d = 1'b0;
		end
		if (delayed_q && tick) begin
			delayCnt_d = delayCnt_q + 4'h1;
		end
		if (startEdge) begin
			edgeTicks_d = 5'h00;
			if (secondEdge) begin
				delayed_d    = 1'b1;
				delayCnt_d   = FIRST_TICK;
				glitchSeen_d = 1'b0;
			end else begin
				receiveIdleStatus_d = 1'b0;
			end
		end
		if (delayDone) begin
			delayed_d           = 1'b0;
			receiveIdleStatus_d = 1'b0;
		end
		if (startBad) begin
			if (delayed_q) begin
				stuck_d = 1'b1;
			end else begin
				glitchSeen_d = 1'b1;
				if (!stuck_q) begin
					receiveIdleStatus_d = 1'b1;
				end
			end
		end
		if (startGood) begin
			stuck_d      = 1'b0;
			glitchSeen_d = 1'b0;
		end
		if (charDone) begin
			receiveIdleStatus_d = 1'b1;
		end
		if (rxReset) begin
			receiveIdleStatus_d = 1'b1;
			glitchSeen_d        = 1'b0;
			delayed_d           = 1'b0;
			stuck_d             = 1'b0;
		end
	end

	// Only continuous receive going low clears overrun; port enable does not
	assign overrunErrorFlag_d = overrunEv ? 1'b1
		: (!ctrl_q.continuousReceiveEnable ? 1'b0
		: overrunErrorFlag_q);
	assign receiveCompleteFlag_d = storeChar ? 1'b1
		: (rdData ? 1'b0 : receiveCompleteFlag_q);

	// Set wins over a write-one clear in the same cycle
	assign intStat_d = rx_events_t'({startBad, stopBad, overrunEv, storeChar})
		| (intStat_q & ~(wrIntStat ? rx_events_t'(regWdata[INT_W-1:0])
		: rx_events_t'(INT_RESET)));

	always_comb begin
		statusWord                  = '0;
		statusWord[ST_OVERRUN_BIT]  = overrunErrorFlag_q;
		statusWord[ST_FRAME_BIT]    = holdFrame_q;
		statusWord[ST_COMPLETE_BIT] = receiveCompleteFlag_q;
		statusWord[ST_IDLE_BIT]     = receiveIdleStatus_q;
	end

	assign rdSel =
		(regAddr == ADDR_CTRL)     ? REG_W'(ctrl_q) :
		(regAddr == ADDR_STATUS)   ? statusWord :
		(regAddr == ADDR_DATA)     ? REG_W'(hold_q) :
		(regAddr == ADDR_BAUD)     ? baud_q :
		(regAddr == ADDR_INT_STAT) ? REG_W'(intStat_q) :
		(regAddr == ADDR_INT_MASK) ? REG_W'(intMask_q) : '0;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q    <= rx_ctrl_t'(CTRL_RESET);
			baud_q    <= BAUD_RESET;
			intStat_q <= rx_events_t'(INT_RESET);
			intMask_q <= rx_events_t'(INT_RESET);
			rdata_q   <= '0;
		end else begin
			if (wrCtrl) begin
				ctrl_q <= rx_ctrl_t'(regWdata[1:0]);
			end
			if (wrBaud) begin
				baud_q <= regWdata;
			end
			if (wrIntMask) begin
				intMask_q <= rx_events_t'(regWdata[INT_W-1:0]);
			end
			intStat_q <= intStat_d;
			rdata_q   <= regRd ? rdSel : '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q   <= RX_IDLE;
			tickCnt_q <= FIRST_TICK;
			bitCnt_q  <= '0;
			shift_q   <= '0;
			rxPrev_q  <= 1'b1;
		end else begin
			state_q   <= state_d;
			tickCnt_q <= tickCnt_d;
			bitCnt_q  <= bitCnt_d;
			shift_q   <= shift_d;
			rxPrev_q  <= rxLevel;
		end
	end

	// The held character survives a receiver reset; only reading drains it
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_q                <= '0;
			holdFrame_q           <= 1'b0;
			receiveCompleteFlag_q <= 1'b0;
			overrunErrorFlag_q    <= 1'b0;
		end else begin
			if (storeChar) begin
				hold_q      <= shift_q;
				holdFrame_q <= stopBad;
			end
			receiveCompleteFlag_q <= receiveCompleteFlag_d;
			overrunErrorFlag_q    <= overrunErrorFlag_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			receiveIdleStatus_q <= 1'b1;
			glitchSeen_q        <= 1'b0;
			edgeTicks_q         <= BIT_TICKS;
			delayed_q           <= 1'b0;
			delayCnt_q          <= FIRST_TICK;
			stuck_q             <= 1'b0;
		end else begin
			receiveIdleStatus_q <= receiveIdleStatus_d;
			glitchSeen_q        <= glitchSeen_d;
			edgeTicks_q         <= edgeTicks_d;
			delayed_q           <= delayed_d;
			delayCnt_q          <= delayCnt_d;
			stuck_q             <= stuck_d;
		end
	end

	assign regRdata = rdata_q;
	assign irq      = |(intStat_q & intMask_q);

endmodule : uart_rx_overrun_idle_status

/* File: testbench/uart_rx_checker.sv */
// Port-level checker for the receiver status and recovery block
`timescale 1ns/1ps
module uart_rx_checker
	import rx_status_pkg::*;
#(
	parameter int unsigned DATA_BITS = 8
) (
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              rxPin,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [REG_W-1:0]  regWdata,
	input wire logic              regWr,
	input wire logic              regRd,
	input wire logic [REG_W-1:0]  regRdata,
	input wire logic              irq
);
	logic              rdAny_q;
	logic [ADDR_W-1:0] rdAddr_q;
	logic [1:0]        ctrl_q;
	logic              baudFresh_q;
	logic              ovrHeld_q;
	logic              maskZero_q;
	wire               rdStat = rdAny_q && rdAddr_q == ADDR_STATUS;
	wire               ctrlWr = regWr && regAddr == ADDR_CTRL;

	// Shadow of what software wrote, so reads can be judged
	always_ff @(posedge clk) begin
		rdAny_q  <= !rst && regRd;
		rdAddr_q <= regAddr;
		if (rst) begin
			ctrl_q      <= 2'h0;
			baudFresh_q <= 1'b1;
			ovrHeld_q   <= 1'b0;
			maskZero_q  <= 1'b1;
		end else begin
			if (ctrlWr)
				ctrl_q <= regWdata[1:0];
			if (regWr && regAddr == ADDR_BAUD)
				baudFresh_q <= 1'b0;
			if (regWr && regAddr == ADDR_INT_MASK)
				maskZero_q <= regWdata[INT_W-1:0] == 4'h0;
			if (ctrlWr && !regWdata[1])
				ovrHeld_q <= 1'b0;
			else if (rdStat && regRdata[ST_OVERRUN_BIT] && ctrl_q[1])
				ovrHeld_q <= 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_rdata_idle_zero: assert property (
		!rdAny_q |-> regRdata == 8'h00) else $error("read data not zero");
	a_unmapped_reads_zero: assert property (
		regRd && regAddr > 3'h5 |=> regRdata == 8'h00)
		else $error("unmapped read not zero");
	a_ctrl_read_back: assert property (
		rdAny_q && rdAddr_q == ADDR_CTRL |-> regRdata == {6'h00, ctrl_q})
		else $error("control readback wrong");
	a_baud_reset_value: assert property (
		rdAny_q && rdAddr_q == ADDR_BAUD && baudFresh_q
		|-> regRdata == BAUD_RESET) else $error("baud reset value wrong");
	a_overrun_held: assert property (
		rdStat && ovrHeld_q |-> regRdata[ST_OVERRUN_BIT])
		else $error("overrun lost without receive disable");
	a_overrun_off_clear: assert property (
		rdStat && !ctrl_q[1] && !$past(ctrl_q[1]) && !$past(ctrl_q[1], 2)
		|-> !regRdata[ST_OVERRUN_BIT]) else $error("overrun not cleared");
	a_idle_when_off: assert property (
		rdStat && ctrl_q != 2'h3 && $past(ctrl_q) != 2'h3
		&& $past(ctrl_q, 2) != 2'h3
		|-> regRdata[ST_IDLE_BIT]) else $error("idle low while off");
	a_status_high_zero: assert property (
		rdStat |-> regRdata[7:4] == 4'h0) else $error("status upper bits set");
	a_irq_masked_off: assert property (
		maskZero_q |-> !irq) else $error("interrupt with mask clear");
endmodule : uart_rx_checker

/* File: testbench/serial_tx_model.sv */
// Remote serial transmitter that drives the receive line
`timescale 1ns/1ps
module serial_tx_model #(
	parameter int BIT_CLKS = 64
) (
	input  wire logic clk,
	output logic      rxPin
);
	initial rxPin = 1'b1;

	// Start, data LSB first, stop; line rests high between frames
	// A low stop level makes a framing error; the line is let high after
	task automatic sendChar(input logic [7:0] d, input logic stopLvl = 1'b1);
		logic [9:0] f;
		f = {stopLvl, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			rxPin <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clk);
		end
		@(posedge clk);
		rxPin <= 1'b1;
	endtask : sendChar

	task automatic glitch(input int n);
		@(posedge clk);
		rxPin <= 1'b0;
		repeat (n) @(posedge clk);
		rxPin <= 1'b1;
	endtask : glitch
endmodule : serial_tx_model

/* File: testbench/uart_rx_overrun_idle_status_tb_top.sv */
// Testbench for the receiver status and recovery block
`timescale 1ns/1ps
module uart_rx_overrun_idle_status_tb_top
	import rx_status_pkg::*;
;
	// BAUD of 3 gives 4 clocks a tick, 64 clocks a bit
	localparam int BIT_CLKS = 64;
	logic              clk      = 1'b0;
	logic              rst;
	logic              rxPin;
	logic [ADDR_W-1:0] regAddr;
	logic [REG_W-1:0]  regWdata;
	logic              regWr;
	logic              regRd;
	logic [REG_W-1:0]  regRdata;
	logic              irq;
	int                errTotal = 0;
	int                cmpCount = 0;

	always #25 clk = ~clk;

	uart_rx_overrun_idle_status #(.DATA_BITS(8)) u_dut (
		.clk(clk), .rst(rst), .rxPin(rxPin), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .irq(irq));
	serial_tx_model #(.BIT_CLKS(BIT_CLKS)) u_tx (.clk(clk), .rxPin(rxPin));

	task automatic check(string n, logic [7:0] got, logic [7:0] exp);
		cmpCount++;
		if (got !== exp) begin
			errTotal++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask : check

	task automatic wr(logic [ADDR_W-1:0] a, logic [7:0] d);
		@(posedge clk);
		regWr    <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr

	task automatic rdChk(string n, logic [ADDR_W-1:0] a, logic [7:0] e);
		@(posedge clk);
		regRd   <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 check(n, regRdata, e);
	endtask : rdChk

	task automatic irqChk(logic e);
		@(posedge clk);
		#1 check("irq", {7'h00, irq}, {7'h00, e});
	endtask : irqChk

	task automatic resetValues();
		rdChk("ctrl", ADDR_CTRL, 8'h00);
		rdChk("baud", ADDR_BAUD, BAUD_RESET);
		rdChk("status", ADDR_STATUS, 8'h08);
		rdChk("unmapped", 3'h6, 8'h00);
		wr(ADDR_STATUS, 8'hFF);
		rdChk("status ro", ADDR_STATUS, 8'h08);
		wr(ADDR_BAUD, 8'h03);
		wr(ADDR_INT_MASK, 8'h01);
		wr(ADDR_CTRL, 8'h03);
		rdChk("ctrl on", ADDR_CTRL, 8'h03);
	endtask : resetValues

	task automatic receiveChar();
		u_tx.sendChar(8'hA5);
		irqChk(1'b1);
		rdChk("status", ADDR_STATUS, 8'h0C);
		rdChk("int", ADDR_INT_STAT, 8'h01);
		rdChk("data", ADDR_DATA, 8'hA5);
		rdChk("status read", ADDR_STATUS, 8'h08);
		wr(ADDR_INT_STAT, 8'h01);
		irqChk(1'b0);
	endtask : receiveChar

	task automatic overrun();
		u_tx.sendChar(8'h3C);
		u_tx.sendChar(8'hC3);
		rdChk("overrun", ADDR_STATUS, 8'h0D);
		wr(ADDR_CTRL, 8'h02);
		rdChk("port off", ADDR_STATUS, 8'h0D);
		wr(ADDR_CTRL, 8'h03);
		rdChk("port on", ADDR_STATUS, 8'h0D);
		wr(ADDR_CTRL, 8'h01);
		rdChk("recv off", ADDR_STATUS, 8'h0C);
		rdChk("held data", ADDR_DATA, 8'h3C);
		wr(ADDR_CTRL, 8'h03);
		wr(ADDR_INT_STAT, 8'h0F);
	endtask : overrun

	task automatic singleGlitch();
		u_tx.glitch(2);
		repeat (20) @(posedge clk);
		rdChk("glitch idle", ADDR_STATUS, 8'h08);
		rdChk("glitch int", ADDR_INT_STAT, 8'h08);
		irqChk(1'b0);
		wr(ADDR_INT_STAT, 8'h08);
		rdChk("int clr", ADDR_INT_STAT, 8'h00);
		repeat (80) @(posedge clk);
	endtask : singleGlitch

	// Software gives up after one character time and resets the receiver
	task automatic stuckIdle(logic [7:0] off);
		u_tx.glitch(2);
		repeat (18) @(posedge clk);
		u_tx.glitch(2);
		repeat (20) @(posedge clk);
		rdChk("idle late", ADDR_STATUS, 8'h08);
		repeat (100) @(posedge clk);
		rdChk("idle low", ADDR_STATUS, 8'h00);
		repeat (700) @(posedge clk);
		rdChk("idle stuck", ADDR_STATUS, 8'h00);
		wr(ADDR_CTRL, off);
		rdChk("idle back", ADDR_STATUS, 8'h08);
		wr(ADDR_CTRL, 8'h03);
		rdChk("idle on", ADDR_STATUS, 8'h08);
		wr(ADDR_INT_STAT, 8'h0F);
	endtask : stuckIdle

	// Stop bit held low: character still buffered, frame error flagged
	task automatic frameError();
		u_tx.sendChar(8'h55, 1'b0);
		rdChk("frame status", ADDR_STATUS, 8'h0E);
		rdChk("frame int", ADDR_INT_STAT, 8'h05);
		rdChk("frame data", ADDR_DATA, 8'h55);
		wr(ADDR_INT_STAT, 8'h0F);
	endtask : frameError

	task automatic end_of_test();
		if (errTotal == 0 && cmpCount > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_of_test

	initial begin
		rst      <= 1'b1;
		regAddr  <= '0;
		regWdata <= '0;
		regWr    <= 1'b0;
		regRd    <= 1'b0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		resetValues();
		receiveChar();
		overrun();
		singleGlitch();
		stuckIdle(8'h01);
		stuckIdle(8'h02);
		frameError();
		end_of_test();
	end

	initial begin
		repeat (20000) @(posedge clk);
		errTotal++;
		end_of_test();
	end
endmodule : uart_rx_overrun_idle_status_tb_top

bind uart_rx_overrun_idle_status uart_rx_checker #(.DATA_BITS(DATA_BITS))
	u_chk (.clk(clk), .rst(rst), .rxPin(rxPin), .regAddr(regAddr),
	.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
	.regRdata(regRdata), .irq(irq));
